// ### logic/catc_regs.svh
// Register offsets, field positions and reset values of the command decoder
`ifndef CATC_REGS_SVH
`define CATC_REGS_SVH

`define CATC_OFF_HDR 4'h0
`define CATC_OFF_LEN 4'h4
`define CATC_OFF_STAT 4'h8
`define CATC_OFF_PEND 4'hc

`define CATC_LEN_LC_LSB 0
`define CATC_LEN_LE_LSB 8
`define CATC_LEN_LCP_BIT 16
`define CATC_LEN_LEP_BIT 17
`define CATC_LEN_RST 18'h00000

`define CATC_PEND_RST 8'h00
`define CATC_P2_SCOPE_BIT 7
`define CATC_P2_NUM_MSB 4
`define CATC_ZERO_BYTE 8'h00

`endif

// ### logic/catc_pkg.sv
// Types shared by the command decoder
package catc_pkg;

   typedef enum logic [2:0] {
      CATC_NONE = 3'b000,
      CATC_AUTH = 3'b001,
      CATC_PROF = 3'b010,
      CATC_WRAP = 3'b011,
      CATC_FETCH = 3'b100,
      CATC_TREPLY = 3'b101,
      CATC_GETRSP = 3'b110,
      CATC_UNKNOWN = 3'b111
   } catc_kind_t;

   typedef struct packed {
      logic [15:0] sw;
      logic [4:0] ref_num;
      logic key_specific;
      logic key_implicit;
      logic err;
      catc_kind_t kind;
   } catc_dec_t;

endpackage

// ### logic/catc_decoder.sv
// Card-side command header decoder with an Avalon-MM register slave
//
// Our own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`include "catc_regs.svh"

// Overview of operation
// - Authentication P1 must be zero
// - P2 b8 picks global or specific key
// - P2 b7 b6 zero, number 01 to 1F
// - P2 zero means application implied key
// - Authentication needs both Lc and Le
// - Toolkit wrap: zero params, Lc, optional Le
// - Fetch: zero params, no Lc, Le
// - Pending response data is flagged to terminal
// - Out of sequence get-response gets technical status
// - Get-response allowed as first command
module catc_decoder #(
   parameter int ADDR_W = 4,
   parameter logic [7:0] INS_AUTH = 8'h01,
   parameter logic [7:0] INS_PROF = 8'h02,
   parameter logic [7:0] INS_WRAP = 8'h03,
   parameter logic [7:0] INS_FETCH = 8'h04,
   parameter logic [7:0] INS_TREPLY = 8'h05,
   parameter logic [7:0] INS_GETRSP = 8'h06,
   parameter logic [15:0] SW_OK = 16'h0001,
   parameter logic [15:0] SW_PARAM = 16'h0002,
   parameter logic [15:0] SW_TECH = 16'h0003,
   parameter logic [15:0] SW_INS = 16'h0004
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Avalon-MM slave
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Decoded command
   output logic dec_pulse,
   output catc_pkg::catc_dec_t dec,
   output logic resp_pend
);

   generate
      if (ADDR_W < 4) begin : g_bad_addr
         $error("ADDR_W must be at least 4");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // Bus handshake: one wait cycle, then the access takes effect

   logic ack_q;
   logic [31:0] rdata_q;
   logic [17:0] len_q;
   logic [31:0] hdr_q;
   logic [7:0] pend_len_q;
   logic pend_q;
   logic first_q;
   logic pulse_q;
   catc_pkg::catc_dec_t dec_q;
   catc_pkg::catc_dec_t dec_d;

   wire req = read | write;
   wire take = req & ack_q;
   wire [3:0] addr = address[3:0];
   wire hit_hdr = addr == `CATC_OFF_HDR;
   wire hit_len = addr == `CATC_OFF_LEN;
   wire hit_stat = addr == `CATC_OFF_STAT;
   wire hit_pend = addr == `CATC_OFF_PEND;
   wire wr_hdr = take & write & hit_hdr;
   wire wr_len = take & write & hit_len;
   wire wr_pend = take & write & hit_pend;

   assign waitrequest = req & ~ack_q;
   assign readdata = rdata_q;
   assign dec = dec_q;
   assign dec_pulse = pulse_q;
   assign resp_pend = pend_q;

   // Unmapped offsets within address[3:0] read as zero and ignore writes; higher address bits are not decoded
   // Status keeps the whole decode word above a spare bit and the flag,
   // so software sees the full status word without a second read
   wire [31:0] rd_mux =
      hit_hdr ? hdr_q :
      hit_len ? {14'h0000, len_q} :
      hit_stat ? {3'b000, dec_q, 1'b0, pend_q} :
      hit_pend ? {24'h000000, pend_len_q} : 32'h00000000;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h00000000;
      end else begin
         ack_q <= req & ~ack_q;
         rdata_q <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Header fields: writedata is {P2, P1, INS, CLA}

   wire [7:0] ins = writedata[15:8];
   wire [7:0] p1 = writedata[23:16];
   wire [7:0] p2 = writedata[31:24];
   wire [7:0] le = len_q[`CATC_LEN_LE_LSB +: 8];
   wire lc_p = len_q[`CATC_LEN_LCP_BIT];
   wire le_p = len_q[`CATC_LEN_LEP_BIT];
   wire pz = (p1 == `CATC_ZERO_BYTE) & (p2 == `CATC_ZERO_BYTE);
   wire p2_zero = p2 == `CATC_ZERO_BYTE;
   wire [4:0] p2_num = p2[`CATC_P2_NUM_MSB:0];

   wire is_auth = ins == INS_AUTH;
   wire is_prof = ins == INS_PROF;
   wire is_wrap = ins == INS_WRAP;
   wire is_fetch = ins == INS_FETCH;
   wire is_trep = ins == INS_TREPLY;
   wire is_gr = ins == INS_GETRSP;
   wire known = is_auth | is_prof | is_wrap | is_fetch | is_trep | is_gr;

   // Application selection is the terminal's duty; not checked here
   wire auth_p1_ok = p1 == `CATC_ZERO_BYTE;
   wire auth_rsv_ok = p2[6:5] == 2'b00;
   wire auth_num_ok = p2_zero | (p2_num != 5'h00);
   wire auth_ok = auth_p1_ok & auth_rsv_ok & auth_num_ok
      & lc_p & le_p;
   wire prof_ok = pz & lc_p & ~le_p;
   wire wrap_ok = pz & lc_p;
   wire fetch_ok = pz & ~lc_p & le_p;
   wire trep_ok = pz & lc_p & ~le_p;
   wire gr_le_ok = (le == `CATC_ZERO_BYTE) | (le == pend_len_q);
   wire gr_ok = pz & ~lc_p & le_p & gr_le_ok;
   // Only the command holding pending data, or power-up, may precede
   wire gr_seq_ok = pend_q | first_q;

   wire par_ok =
      is_auth ? auth_ok :
      is_prof ? prof_ok :
      is_wrap ? wrap_ok :
      is_fetch ? fetch_ok :
      is_trep ? trep_ok : gr_ok;

   wire [2:0] kind_w =
      is_auth ? 3'b001 : is_prof ? 3'b010 : is_wrap ? 3'b011 :
      is_fetch ? 3'b100 : is_trep ? 3'b101 : is_gr ? 3'b110 : 3'b111;

   // Sequence fault outranks field checks for get-response
   wire [15:0] sw_w =
      ~known ? SW_INS :
      (is_gr & ~gr_seq_ok) ? SW_TECH :
      ~par_ok ? SW_PARAM : SW_OK;

   always_comb begin
      dec_d = dec_q;
      if (wr_hdr) begin
         dec_d.kind = catc_pkg::catc_kind_t'(kind_w);
         dec_d.sw = sw_w;
         dec_d.err = sw_w != SW_OK;
         dec_d.key_specific = is_auth & p2[`CATC_P2_SCOPE_BIT];
         dec_d.key_implicit = is_auth & p2_zero;
         dec_d.ref_num = is_auth ? p2_num : 5'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Command state

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         dec_q <= '0;
         hdr_q <= 32'h00000000;
         len_q <= `CATC_LEN_RST;
         pulse_q <= 1'b0;
      end else begin
         dec_q <= dec_d;
         pulse_q <= wr_hdr;
         if (wr_hdr)
            hdr_q <= writedata;
         if (wr_len)
            len_q <= writedata[17:0];
      end
   end

   // Firmware arms pending data after answering a command; any next
   // header consumes it, so a later get-response is out of sequence
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pend_q <= 1'b0;
         pend_len_q <= `CATC_PEND_RST;
         first_q <= 1'b1;
      end else begin
         if (wr_pend) begin
            pend_q <= 1'b1;
            pend_len_q <= writedata[7:0];
         end else if (wr_hdr) begin
            pend_q <= 1'b0;
         end
         if (wr_hdr)
            first_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks

   wait_one_a: assert property (@(posedge sys_clk) disable iff (reset)
      req & waitrequest |=> !waitrequest)
      else $error("request not answered after one wait cycle");

   ack_gap_a: assert property (@(posedge sys_clk) disable iff (reset)
      ack_q |=> !ack_q)
      else $error("two answers in a row");

   gr_seq_a: assert property (@(posedge sys_clk) disable iff (reset)
      wr_hdr & is_gr & !pend_q & !first_q |=> dec_q.sw == SW_TECH)
      else $error("out of sequence get-response not flagged");

   auth_p1_a: assert property (@(posedge sys_clk) disable iff (reset)
      wr_hdr & is_auth & (p1 != 8'h00) |=> dec_q.sw == SW_PARAM && dec_q.err)
      else $error("nonzero authentication P1 accepted");

   auth_rsv_a: assert property (@(posedge sys_clk) disable iff (reset)
      wr_hdr & is_auth & (p2[6:5] != 2'b00) |=> dec_q.err)
      else $error("reserved P2 bits accepted");

   key_impl_a: assert property (@(posedge sys_clk) disable iff (reset)
      wr_hdr & is_auth & p2_zero |=> dec_q.key_implicit && !dec_q.key_specific)
      else $error("zero P2 did not select implied key");

   key_scope_a: assert property (@(posedge sys_clk) disable iff (reset)
      wr_hdr & is_auth |=> dec_q.key_specific == $past(writedata[31])
         && dec_pulse)
      else $error("key scope bit not reported");

   first_gr_a: assert property (@(posedge sys_clk) disable iff (reset)
      wr_hdr & is_gr & first_q & gr_ok |=> dec_q.sw == SW_OK)
      else $error("first get-response refused");

   pend_clr_a: assert property (@(posedge sys_clk) disable iff (reset)
      wr_hdr |=> !resp_pend ##1 !resp_pend || $past(wr_pend))
      else $error("pending data survived a new command");

   fetch_lc_a: assert property (@(posedge sys_clk) disable iff (reset)
      wr_hdr & is_fetch & lc_p |=> dec_q.sw == SW_PARAM)
      else $error("fetch with Lc accepted");

   // A field fault must end in an error status, never in success,
   // because the terminal acts on success without looking further
   num_zero_a: assert property (@(posedge sys_clk) disable iff (reset)
      wr_hdr & is_auth & !p2_zero & (p2_num == 5'h00) |=> dec_q.err)
      else $error("authentication key number zero accepted");

   ref_num_a: assert property (@(posedge sys_clk) disable iff (reset)
      wr_hdr & is_auth |=> dec_q.ref_num == $past(p2_num))
      else $error("key number not reported");

   auth_len_a: assert property (@(posedge sys_clk) disable iff (reset)
      wr_hdr & is_auth & !(lc_p & le_p) |=> dec_q.err)
      else $error("authentication without both lengths accepted");

   prof_le_a: assert property (@(posedge sys_clk) disable iff (reset)
      wr_hdr & is_prof & le_p |=> dec_q.err)
      else $error("profile download with Le accepted");

   wrap_par_a: assert property (@(posedge sys_clk) disable iff (reset)
      wr_hdr & is_wrap & !(pz & lc_p) |=> dec_q.err)
      else $error("bad toolkit wrap parameters accepted");

   fetch_le_a: assert property (@(posedge sys_clk) disable iff (reset)
      wr_hdr & is_fetch & !le_p |=> dec_q.err)
      else $error("fetch without Le accepted");

   trep_le_a: assert property (@(posedge sys_clk) disable iff (reset)
      wr_hdr & is_trep & le_p |=> dec_q.err)
      else $error("terminal reply with Le accepted");

   pend_set_a: assert property (@(posedge sys_clk) disable iff (reset)
      wr_pend |=> resp_pend)
      else $error("pending data not flagged");

   tech_gr_a: assert property (@(posedge sys_clk) disable iff (reset)
      wr_hdr & !is_gr |=> dec_q.sw != SW_TECH)
      else $error("technical status on a command other than get-response");

   gr_len_a: assert property (@(posedge sys_clk) disable iff (reset)
      wr_hdr & is_gr & gr_seq_ok & le_p & !gr_le_ok |=> dec_q.sw == SW_PARAM)
      else $error("get-response with wrong Le accepted");

   ins_bad_a: assert property (@(posedge sys_clk) disable iff (reset)
      wr_hdr & !known |=> dec_q.sw == SW_INS && dec_q.err
         && dec_q.kind == catc_pkg::CATC_UNKNOWN)
      else $error("unknown instruction not rejected");

   pulse_one_a: assert property (@(posedge sys_clk) disable iff (reset)
      dec_pulse |=> !dec_pulse)
      else $error("decode pulse longer than one cycle");

endmodule // catc_decoder

// ### testbench/catc_terminal.sv
// Terminal model: sends commands as Avalon-MM register accesses
`timescale 1ns/1ps
`include "catc_regs.svh"
module catc_terminal (
   // Clock
   input wire logic sys_clk,
   // Avalon-MM master
   output logic [3:0] address,
   output logic read,
   output logic write,
   output logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic waitrequest
);
   initial begin
      address = 4'h0;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
   end
   // Held until waitrequest is sampled low at a rising edge; read data
   // is taken at that edge, and the data lines then show junk
   task automatic xfer(input logic rd, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      @(posedge sys_clk);
      address <= a;
      read <= rd;
      write <= !rd;
      writedata <= d;
      do begin
         @(posedge sys_clk);
      end while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      writedata <= ~d;
   endtask
   // Lengths go first, then the header: one command whole
   task automatic send(input logic [31:0] hdr, input logic [17:0] len);
      logic [31:0] q;
      xfer(1'b0, `CATC_OFF_LEN, {14'h0, len}, q);
      xfer(1'b0, `CATC_OFF_HDR, hdr, q);
   endtask
endmodule // catc_terminal

// ### testbench/catc_decoder_bench.sv
// Self-checking testbench of the card command decoder
`timescale 1ns/1ps
`include "catc_regs.svh"
module catc_decoder_bench;
   localparam logic [15:0] OK = 16'h0001;
   localparam logic [15:0] PA = 16'h0002;
   localparam logic [15:0] TE = 16'h0003;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] address;
   logic read, write, waitrequest, dec_pulse, resp_pend;
   logic [31:0] writedata, readdata, q;
   catc_pkg::catc_dec_t dec;
   int n_errors = 0;
   int n_checks = 0;
   always #5 sys_clk = ~sys_clk;
   catc_decoder u_catc_decoder (.sys_clk(sys_clk), .reset(reset),
      .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .dec_pulse(dec_pulse), .dec(dec),
      .resp_pend(resp_pend));
   catc_terminal u_catc_terminal (.sys_clk(sys_clk), .address(address),
      .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest));
   ////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("errors %0d checks %0d", n_errors, n_checks);
      if (n_errors == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // One command, then the decode; error flag is set for any non-OK status
   task automatic cmd(input logic [7:0] ins, p1, p2, input logic [17:0] len,
                      input logic [15:0] sw, input logic [2:0] k);
      int i;
      u_catc_terminal.send({p2, p1, ins, 8'h00}, len);
      for (i = 0; i < 4 && dec_pulse !== 1'b1; i++) begin
         @(negedge sys_clk);
      end
      check({11'h0, dec_pulse, dec.sw, dec.err, dec.kind},
         {11'h0, 1'b1, sw, sw != OK, k});
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5000) @(posedge sys_clk);
      n_errors++;
      finish_test();
   end
   initial begin
      repeat (16) @(posedge sys_clk);
      reset <= 1'b0;
      cmd(8'h06, 8'h00, 8'h00, 18'h20000, OK, 3'h6);
      cmd(8'h01, 8'h00, 8'h85, 18'h31008, OK, 3'h1);
      check({25'h0, dec.key_specific, dec.key_implicit, dec.ref_num},
         32'h45);
      cmd(8'h01, 8'h00, 8'h1f, 18'h31008, OK, 3'h1);
      check({25'h0, dec.key_specific, dec.key_implicit, dec.ref_num},
         32'h1f);
      cmd(8'h01, 8'h00, 8'h00, 18'h31008, OK, 3'h1);
      check({31'h0, dec.key_implicit}, 32'h1);
      cmd(8'h01, 8'h01, 8'h00, 18'h31008, PA, 3'h1);
      cmd(8'h01, 8'h00, 8'h45, 18'h31008, PA, 3'h1);
      cmd(8'h01, 8'h00, 8'h80, 18'h31008, PA, 3'h1);
      cmd(8'h01, 8'h00, 8'h05, 18'h10008, PA, 3'h1);
      cmd(8'h02, 8'h00, 8'h00, 18'h10008, OK, 3'h2);
      cmd(8'h03, 8'h00, 8'h00, 18'h10008, OK, 3'h3);
      cmd(8'h03, 8'h00, 8'h00, 18'h31008, OK, 3'h3);
      cmd(8'h03, 8'h01, 8'h00, 18'h10008, PA, 3'h3);
      cmd(8'h04, 8'h00, 8'h00, 18'h21000, OK, 3'h4);
      cmd(8'h04, 8'h00, 8'h00, 18'h31008, PA, 3'h4);
      cmd(8'h05, 8'h00, 8'h00, 18'h10008, OK, 3'h5);
      u_catc_terminal.xfer(1'b0, `CATC_OFF_PEND, 32'h10, q);
      u_catc_terminal.xfer(1'b1, `CATC_OFF_STAT, 32'h0, q);
      check(q, 32'h2015);
      check({31'h0, resp_pend}, 32'h1);
      cmd(8'h06, 8'h00, 8'h00, 18'h21000, OK, 3'h6);
      cmd(8'h06, 8'h00, 8'h00, 18'h20000, TE, 3'h6);
      u_catc_terminal.xfer(1'b0, `CATC_OFF_PEND, 32'h10, q);
      u_catc_terminal.xfer(1'b1, `CATC_OFF_PEND, 32'h0, q);
      check(q, 32'h10);
      cmd(8'h06, 8'h00, 8'h00, 18'h21100, PA, 3'h6);
      cmd(8'h07, 8'h00, 8'h00, 18'h10008, 16'h0004, 3'h7);
      u_catc_terminal.xfer(1'b1, 4'h2, 32'h0, q);
      check(q, 32'h0);
      finish_test();
   end
endmodule // catc_decoder_bench
